// ===== verilog/ftcx_pkg.sv
`default_nettype none
package ftcx_pkg;
    localparam int CLK_PERIOD_NS = 8;

    // qualifying times in ns; cycle counts round up to whole clocks
    localparam int T_CANH_FIRST_NS  = 4000;
    localparam int T_CANH_SECOND_NS = 16000;
    localparam int T_CANH_REC_NS    = 8000;
    localparam int T_CANL_BAT_NS    = 8000;
    localparam int T_CANL_REC_NS    = 8000;
    localparam int T_DOM_STUCK_NS   = 16000;
    localparam int T_DIFF_REC_NS    = 8000;
    localparam int T_TXD_DOM_NS     = 30000;
    localparam int T_WAKE_NS        = 20000;
    localparam int T_REMOTE_DOM_NS  = 16000;
    localparam int T_SLEEP_NS       = 24000;

    localparam int CNT_W = 16;
    function automatic logic [CNT_W-1:0] cycles(input int t_ns);
        return CNT_W'((t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction

    localparam int TM_H1    = 0;
    localparam int TM_H2    = 1;
    localparam int TM_HREC  = 2;
    localparam int TM_LBAT  = 3;
    localparam int TM_LREC  = 4;
    localparam int TM_DOM   = 5;
    localparam int TM_DREC  = 6;
    localparam int TM_TXD   = 7;
    localparam int TM_WAKE  = 8;
    localparam int TM_RDOM  = 9;
    localparam int TM_SLEEP = 10;
    localparam int N_TIMERS = 11;

    localparam logic [CNT_W-1:0] TM_LIM [N_TIMERS] = '{
        cycles(T_CANH_FIRST_NS), cycles(T_CANH_SECOND_NS), cycles(T_CANH_REC_NS),
        cycles(T_CANL_BAT_NS), cycles(T_CANL_REC_NS), cycles(T_DOM_STUCK_NS),
        cycles(T_DIFF_REC_NS), cycles(T_TXD_DOM_NS), cycles(T_WAKE_NS),
        cycles(T_REMOTE_DOM_NS), cycles(T_SLEEP_NS)};

    // register map, byte addresses
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0002;
    localparam int          CTRL_TX_OFF    = 0;
    localparam int          CTRL_RWAKE_EN  = 1;
    localparam int          ST_FAULT_LSB   = 0;
    localparam int          ST_TXD_TO      = 4;
    localparam int          ST_OVER_TEMP   = 5;
    localparam int          ST_WAKE        = 6;
    localparam int          ST_POR         = 7;
    localparam int          ST_INH         = 8;
    localparam int          ST_MODE_LSB    = 9;
    localparam int          ST_RXSEL_LSB   = 14;

    localparam logic [1:0] RX_DIFF = 2'h0;
    localparam logic [1:0] RX_CANH = 2'h1;
    localparam logic [1:0] RX_CANL = 2'h2;

    typedef enum logic [4:0] {
        MODE_NORMAL  = 5'h01,
        MODE_GOTO    = 5'h02,
        MODE_SLEEP   = 5'h04,
        MODE_STANDBY = 5'h08,
        MODE_POS     = 5'h10
    } ftcx_mode_e;

    typedef struct packed {
        logic canh_above;
        logic canl_above;
        logic diff_dom;
        logic canh_dom;
        logic canl_dom;
    } ftcx_bus_s;

    typedef struct packed {
        logic l_gnd;
        logic l_bat;
        logic h_fail;
        logic h_single;
    } ftcx_fault_s;
endpackage
`default_nettype wire

// ===== verilog/ftcx_ctrl.sv
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - benign failures keep everything on, differential
// - canh supply short: weak pull-down, receive canl
// - canl ground/battery/bridge: weak pull-up, receive canh
// - canl battery short declared after filter delay
// - auto recovery after recessive qualifying period
// - stuck dominant then time-out to single wire
// - return to differential after recessive period
// - error output low while any failure, normal mode
// - open wire flagged only between nodes
// - standby and enable select the mode
// - sleep floats inhibit, signals wake without supply
// - standby equals sleep with inhibit high
// - power-on standby shows power-on flag, wake
// - normal entry releases wakes, shows receive data
// - battery power-on drives inhibit, sets flag
// - inhibit floats only after held goto-sleep
// - inhibit re-driven only on listed wake events
// - remote wake needs long filtered dominant phase
// - local wake is edge plus stable level
// - wake request shown active low
// - low supply forces standby and enable low
// - over-temperature disables only transmitter stages
// - transmit stuck low disables transmitter
// - canh high: canh single wire, then canl
module ftcx_ctrl (
    input  wire logic               clock_in,
    input  wire logic               rst_in,
    input  wire logic               txd_in,
    input  wire logic               stb_n_in,
    input  wire logic               en_in,
    input  wire logic               wake_n_in,
    input  wire logic               vcc_ok_in,
    input  wire logic               over_temp_in,
    input  wire logic               open_wire_in,
    input  wire ftcx_pkg::ftcx_bus_s bus_in,
    input  wire logic               hsel_in,
    input  wire logic [31:0]        haddr_in,
    input  wire logic [1:0]         htrans_in,
    input  wire logic               hwrite_in,
    input  wire logic [2:0]         hsize_in,
    input  wire logic [31:0]        hwdata_in,
    input  wire logic               hready_in,
    output logic      [31:0]        hrdata_out,
    output logic                    hreadyout_out,
    output logic                    hresp_out,
    output logic                    rxd_out,
    output logic                    err_n_out,
    output logic                    inh_out,
    output logic                    inh_oe_out,
    output logic                    canh_drv_en_out,
    output logic                    canl_drv_en_out,
    output logic                    tx_dom_out,
    output logic                    high_line_term_weak_out,
    output logic                    low_line_term_weak_out,
    output logic                    low_line_term_bat_out
);
    import ftcx_pkg::*;

    function automatic ftcx_mode_e decode_mode(input logic stb, input logic en,
                                               input logic slept);
        ftcx_mode_e m;
        m = MODE_STANDBY;
        unique case ({stb, en})
            2'b11: m = MODE_NORMAL;
            2'b01: m = MODE_GOTO;
            2'b10: m = MODE_POS;
            2'b00: m = slept ? MODE_SLEEP : MODE_STANDBY;
        endcase
        return m;
    endfunction

    ftcx_mode_e       mode;
    ftcx_fault_s      flt;
    logic [CNT_W-1:0] t_cnt [N_TIMERS];
    logic [N_TIMERS-1:0] t_cond;
    logic [N_TIMERS-1:0] t_done;
    logic             sleep_flag;
    logic             inh_on;
    logic             wake_flag;
    logic             por_flag;
    logic             wake_ref;
    logic             stb_prev;
    logic [31:0]      ctrl;
    logic             dphase_wr;
    logic [7:0]       dphase_addr;

    // fail-safe: a collapsing supply must not look like a mode command
    wire eff_stb = stb_n_in & vcc_ok_in;
    wire eff_en  = en_in & vcc_ok_in;
    wire ftcx_mode_e next_mode = decode_mode(eff_stb, eff_en, sleep_flag);
    wire enter_normal = (next_mode == MODE_NORMAL) && (mode != MODE_NORMAL);
    wire is_normal    = (mode == MODE_NORMAL);
    wire stb_rise     = eff_stb & ~stb_prev;

    // one restartable counter per qualifying delay
    assign t_cond[TM_H1]    = bus_in.canh_above;
    assign t_cond[TM_H2]    = bus_in.canh_above;
    assign t_cond[TM_HREC]  = ~bus_in.canh_above;
    assign t_cond[TM_LBAT]  = bus_in.canl_above;
    assign t_cond[TM_LREC]  = ~bus_in.canl_above;
    assign t_cond[TM_DOM]   = bus_in.diff_dom;
    assign t_cond[TM_DREC]  = ~bus_in.diff_dom;
    assign t_cond[TM_TXD]   = ~txd_in;
    assign t_cond[TM_WAKE]  = wake_n_in != wake_ref;
    assign t_cond[TM_RDOM]  = (bus_in.canh_dom & bus_in.canl_dom) & ctrl[CTRL_RWAKE_EN];
    assign t_cond[TM_SLEEP] = next_mode == MODE_GOTO;

    for (genvar i = 0; i < N_TIMERS; i++) begin : g_tm
        always_ff @(posedge clock_in) begin
            if (rst_in || !t_cond[i]) begin
                t_cnt[i] <= '0;
            end else if (t_cnt[i] != TM_LIM[i]) begin
                t_cnt[i] <= t_cnt[i] + CNT_W'(1);
            end
        end
        assign t_done[i] = t_cnt[i] == TM_LIM[i];
    end

    wire local_wake  = t_done[TM_WAKE];
    // remote wake only counts while standby or enable is low
    wire remote_wake = t_done[TM_RDOM] && !(eff_stb && eff_en);
    wire wake_evt    = local_wake | remote_wake | stb_rise;
    wire goto_done   = t_done[TM_SLEEP];
    wire txd_to      = t_done[TM_TXD];
    wire any_fault   = |flt;

    // fault classification; the set and clear terms are mutually exclusive
    ftcx_fault_s next_flt;
    always_comb begin
        next_flt = flt;
        if (t_done[TM_H1])   next_flt.h_single = 1'b1;
        if (t_done[TM_H2])   next_flt.h_fail   = 1'b1;
        if (t_done[TM_HREC]) begin
            next_flt.h_single = 1'b0;
            next_flt.h_fail   = 1'b0;
        end
        if (t_done[TM_LBAT]) next_flt.l_bat = 1'b1;
        if (t_done[TM_LREC]) next_flt.l_bat = 1'b0;
        if (t_done[TM_DOM])  next_flt.l_gnd = 1'b1;
        if (t_done[TM_DREC]) next_flt.l_gnd = 1'b0;
    end

    // receiver path: canl only when canh is lost, else canh on any single-wire fault
    wire [1:0] rx_sel = flt.h_fail ? RX_CANL :
                        (flt.l_bat | flt.l_gnd | flt.h_single) ? RX_CANH : RX_DIFF;
    wire rx_dom = (rx_sel == RX_CANL) ? bus_in.canl_dom :
                  (rx_sel == RX_CANH) ? bus_in.canh_dom : bus_in.diff_dom;

    // thermal and txd time-out kill only the output stages
    wire tx_ok = is_normal & ~over_temp_in & ~txd_to & ~ctrl[CTRL_TX_OFF];
    wire next_canh_en = tx_ok & ~flt.h_fail;
    wire next_canl_en = tx_ok & ~(flt.l_bat | flt.l_gnd);
    wire next_tx_dom  = ~txd_in & tx_ok;

    // open wire only shows through the comparators, so the flag toggles
    wire next_err_n = is_normal ? ~(any_fault | open_wire_in) :
                      (mode == MODE_POS) ? ~por_flag : ~wake_flag;
    wire next_rxd   = is_normal ? ~rx_dom : ~wake_flag;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            mode       <= MODE_STANDBY;
            flt        <= '0;
            stb_prev   <= 1'b0;
            wake_ref   <= 1'b1;
            sleep_flag <= 1'b0;
            inh_on     <= 1'b1;
            por_flag   <= 1'b1;
            wake_flag  <= 1'b0;
        end else begin
            mode     <= next_mode;
            flt      <= next_flt;
            stb_prev <= eff_stb;
            if (local_wake) begin
                wake_ref <= wake_n_in;
            end
            // a wake in the same cycle as goto completion keeps inhibit on
            if (wake_evt) begin
                sleep_flag <= 1'b0;
                inh_on     <= 1'b1;
            end else if (goto_done) begin
                sleep_flag <= 1'b1;
                inh_on     <= 1'b0;
            end
            if (enter_normal) begin
                por_flag  <= 1'b0;
                wake_flag <= 1'b0;
            end else if (!is_normal && (local_wake || remote_wake)) begin
                wake_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rxd_out                 <= 1'b1;
            err_n_out               <= 1'b1;
            inh_out                 <= 1'b1;
            inh_oe_out              <= 1'b1;
            canh_drv_en_out         <= 1'b0;
            canl_drv_en_out         <= 1'b0;
            tx_dom_out              <= 1'b0;
            high_line_term_weak_out <= 1'b0;
            low_line_term_weak_out  <= 1'b0;
            low_line_term_bat_out   <= 1'b1;
        end else begin
            rxd_out                 <= next_rxd;
            err_n_out               <= next_err_n;
            inh_out                 <= inh_on;
            inh_oe_out              <= inh_on;
            canh_drv_en_out         <= next_canh_en;
            canl_drv_en_out         <= next_canl_en;
            tx_dom_out              <= next_tx_dom;
            high_line_term_weak_out <= flt.h_fail;
            low_line_term_weak_out  <= flt.l_bat | flt.l_gnd;
            low_line_term_bat_out   <= next_mode != MODE_NORMAL;
        end
    end

    // ahb-lite slave: zero wait states, always okay, unmapped reads zero
    wire addr_ok   = hsel_in && htrans_in[1] && hready_in;
    wire [31:0] status_word = {16'h0000, rx_sel, mode, inh_on, por_flag, wake_flag,
                               over_temp_in, txd_to, flt};
    wire [31:0] rd_mux = (haddr_in[7:0] == ADDR_CTRL)   ? ctrl :
                         (haddr_in[7:0] == ADDR_STATUS) ? status_word : 32'h0000_0000;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            dphase_wr     <= 1'b0;
            dphase_addr   <= 8'h00;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            ctrl          <= CTRL_RESET;
        end else begin
            dphase_wr     <= addr_ok && hwrite_in;
            dphase_addr   <= haddr_in[7:0];
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            if (addr_ok && !hwrite_in) begin
                hrdata_out <= rd_mux;
            end
            if (dphase_wr && dphase_addr == ADDR_CTRL) begin
                ctrl <= {30'h0000_0000, hwdata_in[1:0]};
            end
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence s_canh_first;
        $rose(flt.h_single);
    endsequence
    sequence s_canh_second;
        flt.h_single && $rose(flt.h_fail);
    endsequence

    a_canh_two_step: assert property ($rose(flt.h_fail) |-> $past(flt.h_single) or s_canh_first)
        else $error("canl mode entered without canh single-wire step");
    a_canh_fail_out: assert property (s_canh_second |=> !canh_drv_en_out && high_line_term_weak_out)
        else $error("canh failure did not cut driver and weaken termination");
    a_canl_fail_out: assert property ((flt.l_bat || flt.l_gnd) |=> !canl_drv_en_out && low_line_term_weak_out)
        else $error("canl failure did not cut driver and weaken termination");
    a_txd_timeout: assert property (txd_to |=> !tx_dom_out && !canh_drv_en_out)
        else $error("transmitter active after txd dominant time-out");
    a_err_normal: assert property ((is_normal && any_fault) |=> !err_n_out)
        else $error("error output high during failure in normal mode");
    a_pos_flag: assert property ((mode == MODE_POS) |=> err_n_out == !$past(por_flag))
        else $error("power-on flag not shown in power-on standby");
    a_goto_float: assert property ((goto_done && !wake_evt) |=> ##1 !inh_oe_out)
        else $error("inhibit not released after goto-sleep");
    a_wake_inh: assert property (wake_evt |=> ##1 inh_oe_out && inh_out)
        else $error("inhibit not driven high after wake event");
    a_normal_clears: assert property (enter_normal |=> !wake_flag && !por_flag)
        else $error("flags not released on entering normal mode");
    a_thermal_off: assert property (over_temp_in |=> !canh_drv_en_out && !canl_drv_en_out)
        else $error("output stages active during over-temperature");
endmodule // ftcx_ctrl
`default_nettype wire

// ===== tb/ftcx_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ftcx_host_model #(
    parameter int HOLD = 3010
) (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic [1:0] req_in,
    input  wire logic       sleep_in,
    input  wire logic       txd_req_in,
    output logic            stb_n_out = 1'b1,
    output logic            en_out = 1'b0,
    output logic            txd_out = 1'b1
);
    int cnt;
    // goto-sleep kept past the qualifying time, only then both low
    always @(posedge clock_in) begin
        txd_out <= txd_req_in | rst_in;
        if (rst_in || !sleep_in) begin
            cnt <= 0;
            {stb_n_out, en_out} <= rst_in ? 2'h2 : req_in;
        end else if (cnt < HOLD) begin
            cnt <= cnt + 1;
            {stb_n_out, en_out} <= 2'h1;
        end else begin
            {stb_n_out, en_out} <= 2'h0;
        end
    end
endmodule // ftcx_host_model
`default_nettype wire

// ===== tb/fault_tolerant_can_xcvr_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module fault_tolerant_can_xcvr_control_test;
    import ftcx_pkg::*;
    localparam int HOLD = int'(TM_LIM[TM_SLEEP]) + 10;
    logic clk = 0, rst = 1, txd_req = 1, sleep_req = 0, wake_n = 1;
    logic vcc_ok = 1, ot = 0, ow = 0, hsel = 0, hwrite = 0;
    logic [1:0] req = 2'h2, htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, st;
    ftcx_bus_s bus = '0;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, rxd, err_n, regulator_inhibit_out, inh_oe, hdrv, ldrv;
    wire logic txdom, hweak, lweak, lbat, stb_n, en, txd;
    int failures = 0, tests_run = 0, cycles = 0, k;
    logic [4:0] f_bus [3] = '{5'h10, 5'h08, 5'h04};
    int f_lim [3] = '{int'(TM_LIM[TM_H2]), int'(TM_LIM[TM_LBAT]), int'(TM_LIM[TM_DOM])};
    logic [1:0] f_rx [3] = '{RX_CANL, RX_CANH, RX_CANH};

    ftcx_host_model #(.HOLD(HOLD)) host_u (.clock_in(clk), .rst_in(rst), .req_in(req),
        .sleep_in(sleep_req), .txd_req_in(txd_req), .stb_n_out(stb_n), .en_out(en),
        .txd_out(txd));
    ftcx_ctrl dut_u (.clock_in(clk), .rst_in(rst), .txd_in(txd), .stb_n_in(stb_n),
        .en_in(en), .wake_n_in(wake_n), .vcc_ok_in(vcc_ok), .over_temp_in(ot),
        .open_wire_in(ow), .bus_in(bus), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .rxd_out(rxd), .err_n_out(err_n), .inh_out(regulator_inhibit_out),
        .inh_oe_out(inh_oe), .canh_drv_en_out(hdrv), .canl_drv_en_out(ldrv),
        .tx_dom_out(txdom), .high_line_term_weak_out(hweak),
        .low_line_term_weak_out(lweak), .low_line_term_bat_out(lbat));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // the whole run is about 24000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            failures++;
            $display("wrong value timeout exp 0 got 1");
            end_sim;
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one single word transfer; no wait is assumed, hready decides
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        st = hrdata;
        chk("hresp", 0, hresp);
    endtask

    task automatic rd(input logic [7:0] a);
        ahb(1'b0, a, 32'h0);
    endtask

    task automatic sleep_now;
        sleep_req <= 1'b1;
        cyc(HOLD + 20);
        chk("inh_oe sleep", 0, inh_oe);
        chk("lbat sleep", 1, lbat);
    endtask

    initial begin
        cyc(2);
        rst <= 1'b0;
        cyc(5);
        chk("inh_oe por", 1, inh_oe);
        chk("err_n pos", 0, err_n);
        rd(ADDR_STATUS);
        chk("mode pos", MODE_POS, st[13:9]);
        chk("por flag", 1, st[ST_POR]);
        req <= 2'h3;
        cyc(5);
        chk("err_n normal", 1, err_n);
        chk("drivers", 2'h3, {hdrv, ldrv});
        rd(ADDR_STATUS);
        chk("por cleared", 0, st[ST_POR]);
        chk("mode normal", MODE_NORMAL, st[13:9]);
        ow <= 1'b1;
        cyc(5);
        chk("err_n open", 0, err_n);
        chk("open drivers", 4'h3, {hweak, lweak, hdrv, ldrv});
        ow <= 1'b0;
        $display("test modes done");
        for (int i = 0; i < 3; i++) begin
            k = i + 1;
            bus <= f_bus[i];
            cyc(f_lim[i] / 2);
            rd(ADDR_STATUS);
            chk("fault early", 0, st[k]);
            if (i == 0)
                chk("h single", {RX_CANH, 1'b1}, {st[15:14], st[0]});
            if (i == 2)
                chk("rxd stuck", 0, rxd);
            cyc(f_lim[i] / 2 + 20);
            rd(ADDR_STATUS);
            chk("fault set", {f_rx[i], 1'b1}, {st[15:14], st[k]});
            chk("err_n fault", 0, err_n);
            chk("fault drv", (i == 0) ? 4'h9 : 4'h6, {hweak, lweak, hdrv, ldrv});
            bus <= '0;
            cyc(1030);
            rd(ADDR_STATUS);
            chk("recovered", {RX_DIFF, 1'b0}, {st[15:14], st[k]});
            chk("err_n clear", 1, err_n);
        end
        $display("test faults done");
        txd_req <= 1'b0;
        cyc(100);
        chk("tx dom", 1, txdom);
        cyc(int'(TM_LIM[TM_TXD]));
        chk("tx timeout", 0, txdom);
        txd_req <= 1'b1;
        cyc(10);
        txd_req <= 1'b0;
        cyc(10);
        chk("tx restart", 1, txdom);
        txd_req <= 1'b1;
        ot <= 1'b1;
        cyc(5);
        chk("hot drv", 2'h0, {hdrv, ldrv});
        rd(ADDR_STATUS);
        chk("hot flag", 1'b1, st[ST_OVER_TEMP]);
        ot <= 1'b0;
        ahb(1'b1, ADDR_CTRL, 32'h3);
        cyc(4);
        chk("tx off", 2'h0, {hdrv, ldrv});
        rd(ADDR_CTRL);
        chk("ctrl", 32'h3, st);
        rd(8'h40);
        chk("unmapped", 32'h0, st);
        ahb(1'b1, ADDR_CTRL, 32'h2);
        cyc(4);
        chk("tx on", 2'h3, {hdrv, ldrv});
        $display("test transmit done");
        sleep_req <= 1'b1;
        cyc(1000);
        sleep_req <= 1'b0;
        cyc(10);
        chk("short goto", 1, inh_oe);
        sleep_now;
        rd(ADDR_STATUS);
        chk("mode sleep", MODE_SLEEP, st[13:9]);
        wake_n <= 1'b0;
        cyc(100);
        wake_n <= 1'b1;
        cyc(50);
        chk("wake glitch", 0, inh_oe);
        wake_n <= 1'b0;
        cyc(int'(TM_LIM[TM_WAKE]) + 20);
        chk("local wake", 4'hC, {inh_oe, regulator_inhibit_out, err_n, rxd});
        rd(ADDR_STATUS);
        chk("mode standby", MODE_STANDBY, st[13:9]);
        sleep_req <= 1'b0;
        vcc_ok <= 1'b0;
        cyc(10);
        rd(ADDR_STATUS);
        chk("failsafe", MODE_STANDBY, st[13:9]);
        vcc_ok <= 1'b1;
        cyc(10);
        chk("wake released", 2'h3, {err_n, rxd});
        sleep_now;
        bus <= 5'h03;
        cyc(500);
        bus <= '0;
        cyc(20);
        chk("remote short", 0, inh_oe);
        bus <= 5'h03;
        cyc(int'(TM_LIM[TM_RDOM]) + 20);
        bus <= '0;
        chk("remote wake", 3'h6, {inh_oe, regulator_inhibit_out, rxd});
        sleep_req <= 1'b0;
        $display("test wake done");
        end_sim;
    end
endmodule // fault_tolerant_can_xcvr_control_test
`default_nettype wire
